/* File: verilog/avrx_core.sv */
// Receiver core: link sampling, unpacking, video output and resets
`include "avrx_params.svh"
`default_nettype none
module avrx_core #(
	parameter int PIXELS_PER_CLOCK = `AVRX_PPC_DEFAULT,
	parameter int MAX_BPC          = `AVRX_MAX_BPC_DEFAULT,
	parameter bit STREAM_MODE      = 1'b1,
	parameter bit LOW_RESO         = 1'b0,
	parameter bit DECRYPT_V14      = 1'b0,
	parameter bit DECRYPT_V22      = 1'b0,
	parameter int LINK_W           = 30
) (
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic                 cpu_reset_n,
	input  wire logic                 stream_reset_n,
	input  wire logic                 audio_reset_n,
	input  wire logic                 link_clk,
	input  wire logic                 video_clk,
	input  wire logic                 stream_clk,
	input  wire logic                 audio_clk,
	input  wire logic                 cpu_clk,
	input  wire logic [LINK_W-1:0]    link_data,
	input  wire logic                 link_is_video,
	input  wire logic                 link_is_audio,
	input  wire logic [`AVRX_BPC_W-1:0] active_bpc,
	input  wire logic [1:0]           color_fmt,
	input  wire logic                 pix_rep_en,
	input  wire logic                 decrypt_key_en,
	output logic [LINK_W-1:0]         video_data,
	output logic                      video_valid,
	input  wire logic                 video_ready,
	output logic [LINK_W-1:0]         audio_data,
	output logic                      audio_valid,
	output logic [LINK_W-1:0]         aux_data,
	output logic                      aux_valid,
	output logic                      video_reset,
	output logic                      bpc_error,
	output logic                      rep_error,
	output logic                      cpu_idle,
	output logic                      stream_idle,
	output logic                      audio_idle
);
	// Build options checked at the start of simulation
	initial begin
		if (PIXELS_PER_CLOCK != 2 && PIXELS_PER_CLOCK != 4)
			$error("pixels_per_clock must be 2 or 4");
		if (MAX_BPC != 8 && MAX_BPC != 10 && MAX_BPC != 12 && MAX_BPC != 16)
			$error("maximum bits per component invalid");
	end

	// Link clock and data synchronisers, two stages each
	logic       lclk_s1, lclk_s2, lclk_d;  // Link clock sampling
	logic [LINK_W+1:0] ld_s1, ld_s2;        // Data plus kind flags
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lclk_s1 <= 1'b0;
			lclk_s2 <= 1'b0;
			lclk_d  <= 1'b0;
			ld_s1   <= '0;
			ld_s2   <= '0;
		end else begin
			lclk_s1 <= link_clk;
			lclk_s2 <= lclk_s1;
			lclk_d  <= lclk_s2;
			ld_s1   <= {link_is_audio, link_is_video, link_data};
			ld_s2   <= ld_s1;
		end
	end
	logic link_rise;  // One pulse per link word
	assign link_rise = lclk_s2 && !lclk_d;

	// Interface reset synchronisers, each on its own interface clock
	logic [1:0] cpu_rs, str_rs, aud_rs;
	always_ff @(posedge cpu_clk or negedge cpu_reset_n) begin
		if (!cpu_reset_n)
			cpu_rs <= 2'h0;
		else
			cpu_rs <= {cpu_rs[0], 1'b1};
	end
	always_ff @(posedge stream_clk or negedge stream_reset_n) begin
		if (!stream_reset_n)
			str_rs <= 2'h0;
		else
			str_rs <= {str_rs[0], 1'b1};
	end
	always_ff @(posedge audio_clk or negedge audio_reset_n) begin
		if (!audio_reset_n)
			aud_rs <= 2'h0;
		else
			aud_rs <= {aud_rs[0], 1'b1};
	end
	assign cpu_idle    = !cpu_rs[1];
	assign stream_idle = !str_rs[1];
	assign audio_idle  = !aud_rs[1];

	// Run levels carried into the core clock; a slow level, so two
	// flops suffice, at the price of two cycles of lag
	logic [1:0] str_ok;  // Stream run level on clk
	logic [1:0] aud_ok;  // Audio run level on clk
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			str_ok <= 2'h0;
			aud_ok <= 2'h0;
		end else begin
			str_ok <= {str_ok[0], str_rs[1]};
			aud_ok <= {aud_ok[0], aud_rs[1]};
		end
	end

	// Video path enable: stream mode uses its reset, native always runs
	logic vid_run;
	assign vid_run = STREAM_MODE ? str_ok[1] : 1'b1;

	// Native video reset output, held a few cycles after core reset
	logic [3:0] vrst_cnt;  // Stretch counter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			vrst_cnt    <= 4'h0;
			video_reset <= 1'b1;
		end else begin
			if (vrst_cnt != `AVRX_RST_HOLD)
				vrst_cnt <= vrst_cnt + 4'h1;
			video_reset <= !STREAM_MODE && (vrst_cnt != `AVRX_RST_HOLD);
		end
	end

	// Option checks on run-time settings
	// Build maximum at the width of the run-time setting
	localparam logic [`AVRX_BPC_W-1:0] BPC_LIMIT =
		MAX_BPC[`AVRX_BPC_W-1:0];
	logic fmt_ok;
	assign fmt_ok = (color_fmt == `AVRX_FMT_RGB) ||
			(color_fmt == `AVRX_FMT_444);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bpc_error <= 1'b0;
			rep_error <= 1'b0;
		end else begin
			bpc_error <= (active_bpc > BPC_LIMIT);
			rep_error <= pix_rep_en && (!LOW_RESO || !fmt_ok);
		end
	end

	// Decryption stage: a keyed scramble stands for an included engine
	logic [LINK_W-1:0] plain;
	logic              dec_on;
	assign dec_on = (DECRYPT_V14 || DECRYPT_V22) && decrypt_key_en;
	assign plain  = dec_on ? ~ld_s2[LINK_W-1:0] : ld_s2[LINK_W-1:0];

	// Pixel repetition: the first video word of each pair dropped when enabled
	logic rep_phase;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rep_phase <= 1'b0;
		else if (link_rise && ld_s2[LINK_W] && pix_rep_en && !rep_error)
			rep_phase <= ~rep_phase;
	end

	// Unpacker: sorts each link word by kind
	avrx_pkg::avrx_state_e state;
	logic                  vid_push;
	logic                  vid_in_ready;
	logic [LINK_W-1:0]     vid_word;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= avrx_pkg::AVRX_IDLE;
		end else if (link_rise) begin
			case ({ld_s2[LINK_W+1], ld_s2[LINK_W]})
			2'b01:   state <= avrx_pkg::AVRX_VIDEO;
			2'b00:   state <= avrx_pkg::AVRX_AUX;
			default: state <= avrx_pkg::AVRX_IDLE;
			endcase
		end else begin
			state <= avrx_pkg::AVRX_IDLE;
		end
	end
	// Captured word for the chosen path
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			vid_word    <= '0;
			audio_data  <= '0;
			audio_valid <= 1'b0;
			aux_data    <= '0;
			aux_valid   <= 1'b0;
		end else begin
			audio_valid <= 1'b0;
			aux_valid   <= 1'b0;
			if (link_rise) begin
				case ({ld_s2[LINK_W+1], ld_s2[LINK_W]})
				2'b01: begin
					vid_word <= plain;
				end
				2'b10: begin
					audio_data  <= plain;
					audio_valid <= aud_ok[1];
				end
				default: begin
					aux_data  <= plain;
					aux_valid <= 1'b1;
				end
				endcase
			end
		end
	end
	assign vid_push = (state == avrx_pkg::AVRX_VIDEO) && vid_run &&
			!rep_phase;

	// Two-entry buffer toward the video output; a full buffer drops
	// the word since the link cannot be paused
	avrx_skid #(.W(LINK_W)) u_buf (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_data   (vid_word),
		.in_valid  (vid_push),
		.in_ready  (vid_in_ready),
		.out_data  (video_data),
		.out_valid (video_valid),
		.out_ready (video_ready && vid_run)
	);

	// Video words appear only after a sorted video word
	AST_VID_PUSH: assert property (
		@(posedge clk) disable iff (!reset_n)
		vid_push |-> $past(link_rise) && $past(ld_s2[LINK_W]))
		else $error("video push without link video word");
	// Idle stream interface offers nothing
	AST_STREAM_IDLE: assert property (
		@(posedge clk) disable iff (!reset_n)
		(STREAM_MODE && !str_ok[1]) |-> !vid_push)
		else $error("video pushed while stream reset");
	// Video reset released in native mode within the hold time
	AST_VRST: assert property (
		@(posedge clk) disable iff (!reset_n)
		(vrst_cnt == `AVRX_RST_HOLD) |=> !video_reset)
		else $error("video reset stuck");
	// Bpc check follows the setting by one cycle
	AST_BPC: assert property (
		@(posedge clk) disable iff (!reset_n)
		(active_bpc > BPC_LIMIT) |=> bpc_error)
		else $error("bpc overrun not flagged");
	// Repetition refused for other formats
	AST_REP: assert property (
		@(posedge clk) disable iff (!reset_n)
		(pix_rep_en && !fmt_ok) |=> rep_error)
		else $error("repetition allowed on bad format");
	// Audio words only outside audio reset
	AST_AUD: assert property (
		@(posedge clk) disable iff (!reset_n)
		audio_valid |-> $past(aud_ok[1]))
		else $error("audio word during reset");
	// Link edge is a single pulse
	AST_EDGE: assert property (
		@(posedge clk) disable iff (!reset_n)
		link_rise |=> !link_rise)
		else $error("link edge pulse too long");
	// Decryption only when built in
	AST_DEC: assert property (
		@(posedge clk) disable iff (!reset_n)
		(!DECRYPT_V14 && !DECRYPT_V22) |-> !dec_on)
		else $error("decryption active though not built");
	// Audio word sorted while the audio side runs
	sequence seq_audio_word;
		link_rise && ld_s2[LINK_W+1] && !ld_s2[LINK_W] && aud_ok[1];
	endsequence
	// The same word offered on the audio output
	sequence seq_audio_out;
		audio_valid && (audio_data == $past(plain));
	endsequence
	// An audio word is handed on one cycle after it is sorted
	AST_AUD_WORD: assert property (
		@(posedge clk) disable iff (!reset_n)
		seq_audio_word |=> seq_audio_out)
		else $error("audio word not handed on");
endmodule
`default_nettype wire

/* File: shared/avrx_params.svh */
// Constants for the receiver clock, reset and build-option framework
`ifndef AVRX_PARAMS_SVH
`define AVRX_PARAMS_SVH
`define AVRX_PPC_DEFAULT      2
`define AVRX_MAX_BPC_DEFAULT  8
`define AVRX_BPC_W            5
`define AVRX_PIX_W            16
`define AVRX_PIX_REP_FACTOR   2
`define AVRX_FMT_RGB          2'h0
`define AVRX_FMT_444          2'h1
`define AVRX_WORD_BYTES       4
`define AVRX_RST_HOLD         4'h3
`endif

/* File: shared/avrx_pkg.sv */
// Shared types for the receiver framework
`default_nettype none
package avrx_pkg;
	// Unpacker state, one-hot
	typedef enum logic [2:0] {
		AVRX_IDLE  = 3'b001,
		AVRX_VIDEO = 3'b010,
		AVRX_AUX   = 3'b100
	} avrx_state_e;
	// Colour format code
	typedef logic [1:0] avrx_fmt_t;
endpackage
`default_nettype wire

/* File: verilog/avrx_skid.sv */
// Two-entry buffer with valid/ready on both sides
`default_nettype none
module avrx_skid #(
	parameter int W = 32
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	logic [W-1:0] mem [2];  // Storage, flip-flops
	logic         wr_ptr;   // Write index
	logic         rd_ptr;   // Read index
	logic [1:0]   count;    // Fill level
	logic         push;
	logic         pop;

	assign in_ready  = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	// Pointers and level
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	// Storage write, no reset needed on data
	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Never overfill, never underflow
	AST_SKID_LEVEL: assert property (@(posedge clk) disable iff (!reset_n)
		count <= 2'h2) else $error("buffer level out of range");
endmodule
`default_nettype wire

/* File: verification/avrx_link_model.sv */
// Link-side partner model: sends words on a slow, gated link clock
`default_nettype none
module avrx_link_model #(
	parameter int LW = 30
) (
	output logic          link_clk,
	output logic [LW-1:0] link_data,
	output logic          link_is_video,
	output logic          link_is_audio
);
	timeunit 1ns;
	timeprecision 1ps;

	// Clock parked low between words, it never runs free
	initial begin
		link_clk      = 1'b0;
		link_data     = '0;
		link_is_video = 1'b0;
		link_is_audio = 1'b0;
	end

	// One word per 160 ns period, stable around the rising edge; the
	// link clock stands for a quarter of the data clock, which below
	// the threshold is also the cable clock
	task automatic send(input logic [LW-1:0] d, input logic v,
		input logic a);
		link_data     <= d;
		link_is_video <= v;
		link_is_audio <= a;
		#40 link_clk <= 1'b1;
		#80 link_clk <= 1'b0;
		// Released bus shows the inverse so a stale word cannot pass
		#20 link_data <= ~d;
		// Keep the next word's change out of this time step
		#20;
	endtask
endmodule
`default_nettype wire

/* File: verification/tb_av_rx_clock_reset_config.sv */
// Testbench for the receiver core in native video mode
`default_nettype none
module tb_av_rx_clock_reset_config;
	timeunit 1ns;
	timeprecision 1ps;

	// One table row: link word and its flags
	typedef struct packed {
		logic [29:0] d;
		logic        v;
		logic        a;
	} avrx_row_s;

	logic        clk = 1'b0;
	logic        oclk = 1'b0;     // Shared stand-in for idle clocks
	logic        reset_n = 1'b0;
	logic [2:0]  irst_n = 3'h0;   // Audio, stream, cpu resets
	logic        link_clk;
	logic [29:0] link_data;
	logic        link_is_video;
	logic        link_is_audio;
	logic [4:0]  active_bpc = 5'h08;
	logic [1:0]  color_fmt = 2'h0;
	logic        pix_rep_en = 1'b0;
	logic        decrypt_key_en = 1'b0;
	logic        video_ready = 1'b1;
	logic [29:0] video_data, audio_data, aux_data;
	logic        video_valid, audio_valid, aux_valid, video_reset;
	logic        bpc_error, rep_error, cpu_idle, stream_idle, audio_idle;
	logic [29:0] q_v[$];          // Video words taken
	logic [29:0] got_a, got_x;
	logic        seen_a, seen_x;
	int          n_fail = 0;
	int          checks_done = 0;
	int          cyc = 0;
	avrx_row_s   rows[5] = '{
		'{30'h0000_0001, 1'b1, 1'b0}, '{30'h3fff_ffff, 1'b0, 1'b1},
		'{30'h1555_5555, 1'b0, 1'b0}, '{30'h2aaa_aaaa, 1'b1, 1'b1},
		'{30'h3000_0000, 1'b1, 1'b0}};

	always #5 clk = ~clk;
	always #3 oclk = ~oclk;

	avrx_link_model #(.LW(30)) link (.link_clk(link_clk),
		.link_data(link_data), .link_is_video(link_is_video),
		.link_is_audio(link_is_audio));

	// Native mode with the repetition option built in
	avrx_core #(
		.STREAM_MODE (1'b0),
		.LOW_RESO    (1'b1)
	) dut (.clk(clk), .reset_n(reset_n),
		.cpu_reset_n(irst_n[0]), .stream_reset_n(irst_n[1]),
		.audio_reset_n(irst_n[2]), .link_clk(link_clk),
		.video_clk(oclk), .stream_clk(oclk), .audio_clk(oclk),
		.cpu_clk(oclk), .link_data(link_data),
		.link_is_video(link_is_video), .link_is_audio(link_is_audio),
		.active_bpc(active_bpc), .color_fmt(color_fmt),
		.pix_rep_en(pix_rep_en), .decrypt_key_en(decrypt_key_en),
		.video_data(video_data), .video_valid(video_valid),
		.video_ready(video_ready), .audio_data(audio_data),
		.audio_valid(audio_valid), .aux_data(aux_data),
		.aux_valid(aux_valid), .video_reset(video_reset),
		.bpc_error(bpc_error), .rep_error(rep_error),
		.cpu_idle(cpu_idle), .stream_idle(stream_idle),
		.audio_idle(audio_idle));

	// Mid-cycle capture, away from the edge where outputs move
	always @(negedge clk) begin
		if (video_valid === 1'b1 && video_ready === 1'b1)
			q_v.push_back(video_data);
		if (audio_valid === 1'b1) begin
			got_a = audio_data;
			seen_a = 1'b1;
		end
		if (aux_valid === 1'b1) begin
			got_x = aux_data;
			seen_x = 1'b1;
		end
	end

	task automatic chk(input string nm, input logic [29:0] e, g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Hang guard, well above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			finish_test();
		end
	end

	initial begin
		logic vid, aud;
		seen_a = 1'b0;
		seen_x = 1'b0;
		// All resets held together until clocks run
		repeat (10) @(posedge clk);
		chk("video_reset in reset", 30'h1, 30'(video_reset));
		chk("idle in reset", 30'h7,
			30'({audio_idle, stream_idle, cpu_idle}));
		reset_n <= 1'b1;
		irst_n <= 3'h7;
		repeat (8) @(posedge clk);
		chk("video_reset after", 30'h0, 30'(video_reset));
		// Each interface reset alone idles only its own side
		for (int k = 0; k < 3; k++) begin
			irst_n <= ~(3'h1 << k);
			repeat (4) @(posedge clk);
			chk("idle one", 30'(3'h1 << k),
				30'({audio_idle, stream_idle, cpu_idle}));
			irst_n <= 3'h7;
			repeat (4) @(posedge clk);
		end
		// Table of link words; decryption is not built in
		decrypt_key_en <= 1'b1;
		foreach (rows[i]) begin
			seen_a = 1'b0;
			seen_x = 1'b0;
			q_v.delete();
			link.send(rows[i].d, rows[i].v, rows[i].a);
			repeat (4) @(posedge clk);
			vid = rows[i].v & ~rows[i].a;
			aud = rows[i].a & ~rows[i].v;
			chk("video count", 30'(vid), 30'(q_v.size()));
			chk("audio seen", 30'(aud), 30'(seen_a));
			chk("aux seen", 30'(!(vid | aud)), 30'(seen_x));
			if (vid)
				chk("video data", rows[i].d, q_v[0]);
			if (aud)
				chk("audio data", rows[i].d, got_a);
			if (!(vid | aud))
				chk("aux data", rows[i].d, got_x);
		end
		decrypt_key_en <= 1'b0;
		// Stalled receiver: two words kept, the third refused
		video_ready <= 1'b0;
		q_v.delete();
		for (int i = 0; i < 3; i++)
			link.send(30'(9'h100 + i), 1'b1, 1'b0);
		repeat (4) @(posedge clk);
		chk("valid held", 30'h1, 30'(video_valid));
		video_ready <= 1'b1;
		repeat (6) @(posedge clk);
		chk("kept count", 30'h2, 30'(q_v.size()));
		chk("kept first", 30'h100, q_v[0]);
		chk("kept second", 30'h101, q_v[1]);
		chk("drained", 30'h0, 30'(video_valid));
		// Depth above the build maximum of 8 is flagged
		for (int b = 7; b < 11; b++) begin
			active_bpc <= 5'(b);
			repeat (3) @(posedge clk);
			chk("bpc_error", 30'(b > 8), 30'(bpc_error));
		end
		active_bpc <= 5'h08;
		// Repetition allowed for RGB and 4:4:4 only
		pix_rep_en <= 1'b1;
		for (int f = 0; f < 4; f++) begin
			color_fmt <= 2'(f);
			repeat (3) @(posedge clk);
			chk("rep_error", 30'(f > 1), 30'(rep_error));
		end
		pix_rep_en <= 1'b0;
		repeat (3) @(posedge clk);
		chk("rep_error off", 30'h0, 30'(rep_error));
		// Repetition by two keeps one word of each pair
		color_fmt <= 2'h0;
		pix_rep_en <= 1'b1;
		q_v.delete();
		repeat (3) @(posedge clk);
		link.send(30'h0000_0aaa, 1'b1, 1'b0);
		link.send(30'h0000_0bbb, 1'b1, 1'b0);
		repeat (4) @(posedge clk);
		chk("repeat count", 30'h1, 30'(q_v.size()));
		pix_rep_en <= 1'b0;
		// Second core reset mid-run, then a word after its release
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk("video_reset again", 30'h1, 30'(video_reset));
		chk("valid in reset", 30'h0, 30'(video_valid));
		reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk("video_reset freed", 30'h0, 30'(video_reset));
		q_v.delete();
		link.send(30'h0123_4567, 1'b1, 1'b0);
		repeat (4) @(posedge clk);
		chk("count after reset", 30'h1, 30'(q_v.size()));
		chk("word after reset", 30'h0123_4567, q_v[0]);
		finish_test();
	end
endmodule
`default_nettype wire
